/* File: poc_output_ctrl.sv */
// converter digital side: correction pipeline, output pins, straps, avalon registers
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
// Function
// [R1] output enable high floats all ten bits
// [R2] undriven output enable reads as low
// [R3] sleep request high shuts the converter down
// [R4] span strap high 2V, low 1V
// [R5] reference strap high external, low internal
// [R6] pin bit 1 msb, bit 10 lsb
// [R7] word appears five clocks after its sample
// [R8] output word updates on rising clock edge
// [R9] nine stages merged by error correction
// [R10] sample taken on rising convert clock edge
// [R11] straight offset binary, msb flip gives twos
// [R12] undriven straps read high via pull-ups
// [R13] receiver drops words until latency elapsed
// [R14] receiver latches between successive rising edges
module poc_output_ctrl
  import poc_pkg::*;
#(
  parameter int FIFO_DEPTH = POC_FIFO_DEPTH
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [POC_CODE_W-1:0] stage_code_in,
  input wire logic oe_n_in,
  input wire logic oe_n_driven_in,
  input wire logic sleep_request_in,
  input wire logic input_span_select_in,
  input wire logic input_span_select_driven_in,
  input wire logic reference_source_select_in,
  input wire logic reference_source_select_driven_in,
  output logic [1:POC_WORD_W] sample_word_out,
  output logic [1:POC_WORD_W] sample_word_oe_out,
  output logic span_2v_out,
  output logic ext_ref_out,
  output logic shutdown_out,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // ***************************************************************
  // pin synchronisers: first stage is read by the second only
  // ***************************************************************
  logic [POC_CODE_W-1:0] code_s1_ff;
  logic [POC_CODE_W-1:0] code_s2_ff;
  logic [4:0] pin_s1_ff;
  logic [4:0] pin_s2_ff;
  logic run_ff;
  wire logic [4:0] pin_raw = {oe_n_in, oe_n_driven_in, input_span_select_in,
                               input_span_select_driven_in, sleep_request_in};
  wire logic oe_n_sync = pin_s2_ff[4];
  wire logic oe_drv_sync = pin_s2_ff[3];
  wire logic span_sync = pin_s2_ff[2];
  wire logic span_drv_sync = pin_s2_ff[1];
  wire logic sleep_sync = pin_s2_ff[0];
  logic [1:0] ref_s1_ff;
  logic [1:0] ref_s2_ff;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      ref_s1_ff <= '0;
      ref_s2_ff <= '0;
    end
    else
    begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      ref_s1_ff <= {reference_source_select_in, reference_source_select_driven_in};
      ref_s2_ff <= ref_s1_ff;
    end
  end

  // ***************************************************************
  // strap and control decode
  // ***************************************************************
  logic [2:0] ctrl_ff;
  wire logic oe_n_eff = oe_drv_sync ? oe_n_sync : 1'b0; // [R2]
  wire logic span_eff = span_drv_sync ? span_sync : 1'b1; // [R4] [R12]
  wire logic ref_eff = ref_s2_ff[0] ? ref_s2_ff[1] : 1'b1; // [R5] [R12]
  wire logic nxt_shutdown = sleep_sync || ctrl_ff[POC_CTRL_SLEEP_BIT]; // [R3]

  assign span_2v_out = span_eff;
  assign ext_ref_out = ref_eff;
  assign shutdown_out = !run_ff;

  // ***************************************************************
  // sampling and correction pipeline; frozen while shut down
  // ***************************************************************
  logic [POC_WORD_W-1:0] align_ff [POC_ALIGN_DEPTH];
  wire logic [POC_WORD_W-1:0] corrected = poc_correct(code_s2_ff); // [R9]
  wire logic [POC_WORD_W-1:0] out_word = align_ff[POC_ALIGN_DEPTH-1];

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      run_ff <= 1'b0;
      code_s1_ff <= '0;
      code_s2_ff <= '0;
    end
    else
    begin
      run_ff <= !nxt_shutdown; // [R3]
      if (run_ff)
      begin
        code_s1_ff <= stage_code_in; // [R10]
        code_s2_ff <= code_s1_ff;
      end
    end
  end

  // the delay line pads the sync and correction cycles out to five
  for (genvar i = 0; i < POC_ALIGN_DEPTH; i++)
  begin : g_align
    wire logic [POC_WORD_W-1:0] src = (i == 0) ? corrected : align_ff[(i == 0) ? 0 : i-1];
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
        align_ff[i] <= '0;
      else if (run_ff)
        align_ff[i] <= src; // [R7] [R8]
    end
  end

  // ascending pin vector puts the msb on bit 1
  assign sample_word_out = out_word; // [R6] [R11]
  assign sample_word_oe_out = {POC_WORD_W{!oe_n_eff}}; // [R1]

  // ***************************************************************
  // capture fifo; full drops the captured word and flags an overrun
  // ***************************************************************
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [POC_WORD_W-1:0] fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic overrun_ff;
  logic fifo_pop;
  wire logic cap_valid = run_ff && ctrl_ff[POC_CTRL_CAPTURE_BIT];
  wire logic cap_lost = cap_valid && !fifo_in_ready;

  poc_fifo #(.WIDTH(POC_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(cap_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(out_word),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_data),
    .level_out(fifo_level)
  );

  // ***************************************************************
  // avalon slave: one wait cycle, then the accepting edge
  // ***************************************************************
  poc_bus_state_t bus_ff;
  poc_bus_state_t nxt_bus;
  logic [31:0] rdata_ff;
  wire logic req = avs_read_in || avs_write_in;
  wire logic accept = req && (bus_ff == POC_BUS_ACK);
  wire logic sel_ctrl = (avs_address_in == POC_CTRL_OFS);
  wire logic sel_status = (avs_address_in == POC_STATUS_OFS);
  wire logic sel_data = (avs_address_in == POC_DATA_OFS);
  wire logic wr_ctrl = accept && avs_write_in && sel_ctrl && avs_byteenable_in[0];
  wire logic wr_status = accept && avs_write_in && sel_status && avs_byteenable_in[0];
  wire logic ovr_clear = wr_status && avs_writedata_in[POC_ST_OVERRUN_BIT];
  wire logic [POC_WORD_W-1:0] fifo_word = ctrl_ff[POC_CTRL_TWOS_BIT]
                                        ? {~fifo_out_data[POC_WORD_W-1], fifo_out_data[POC_WORD_W-2:0]}
                                        : fifo_out_data; // [R11]
  wire logic [31:0] status_word = {{(32-POC_ST_LEVEL_LSB-LW){1'b0}}, fifo_level, 2'h0,
                                   !fifo_in_ready, !fifo_out_valid, overrun_ff,
                                   ref_eff, span_eff, !run_ff};
  wire logic [31:0] data_word = {fifo_out_valid, {(31-POC_WORD_W){1'b0}}, fifo_word};
  wire logic [31:0] rd_mux = sel_ctrl ? {29'h0, ctrl_ff}
                           : sel_status ? status_word
                           : sel_data ? data_word
                           : 32'h0000_0000;

  assign fifo_pop = accept && avs_read_in && sel_data;
  assign avs_waitrequest_out = req && (bus_ff == POC_BUS_IDLE);
  assign avs_readdata_out = rdata_ff;

  always_comb
  begin
    case (bus_ff)
      POC_BUS_IDLE: nxt_bus = req ? POC_BUS_ACK : POC_BUS_IDLE;
      POC_BUS_ACK: nxt_bus = POC_BUS_IDLE;
      default: nxt_bus = POC_BUS_IDLE;
    endcase
  end

  // readdata loads in the wait cycle so it stands at the accepting edge
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      bus_ff <= POC_BUS_IDLE;
      rdata_ff <= '0;
    end
    else
    begin
      bus_ff <= nxt_bus;
      if (req && bus_ff == POC_BUS_IDLE)
        rdata_ff <= avs_read_in ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ctrl_ff <= POC_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_ff <= avs_writedata_in[2:0];
  end

  // a lost word in the clearing cycle keeps the flag set
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      overrun_ff <= 1'b0;
    else if (cap_lost)
      overrun_ff <= 1'b1;
    else if (ovr_clear)
      overrun_ff <= 1'b0;
  end

  // ***************************************************************
  // assertions and covers
  // ***************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_output_float_hi: assert property ((oe_n_driven_in && oe_n_in)[*3] // [R1]
    |-> sample_word_oe_out == '0)
    else $error("outputs driven while enable is high");
  a_oe_pulldown_drive: assert property ((!oe_n_driven_in)[*3] |-> &sample_word_oe_out) // [R2]
    else $error("undriven enable did not drive outputs");
  a_sleep_freeze_out: assert property (!run_ff |=> $stable(out_word)) // [R3]
    else $error("word changed during shutdown");
  a_sleep_enter_two: assert property (sleep_request_in[*3] |=> shutdown_out) // [R3]
    else $error("sleep request not honoured");
  a_span_strap_low: assert property ( // [R4]
    (input_span_select_driven_in && !input_span_select_in)[*3] |-> !span_2v_out)
    else $error("driven low span strap not 1V");
  a_span_pullup_high: assert property ((!input_span_select_driven_in)[*3] |-> span_2v_out) // [R12]
    else $error("open span strap not 2V");
  a_ref_internal_sel: assert property ( // [R5]
    (reference_source_select_driven_in && !reference_source_select_in)[*3] |-> !ext_ref_out)
    else $error("low reference strap not internal");
  a_ref_pullup_ext: assert property ((!reference_source_select_driven_in)[*3] |-> ext_ref_out) // [R12]
    else $error("open reference strap not external");
  a_latency_five_cyc: assert property (run_ff[*5] ##1 1'b1 // [R7]
    |-> out_word == poc_correct($past(stage_code_in, 5)))
    else $error("output word not five clocks behind sample");
  a_msb_on_pin1: assert property ( // [R6]
    (run_ff && code_s2_ff == POC_MID_CODES) ##1 run_ff[*2] |=> sample_word_out == POC_MID_WORD)
    else $error("msb not on pin bit 1");
  a_mid_code_corr: assert property ((run_ff && code_s2_ff == POC_MID_CODES) // [R9]
    |=> align_ff[0] == POC_MID_WORD)
    else $error("mid-scale correction wrong");
  a_capture_rise: assert property (run_ff |=> code_s1_ff == $past(stage_code_in)) // [R10]
    else $error("sample not taken on rising edge");
  a_word_on_edge: assert property (!$stable(out_word) |-> $past(run_ff)) // [R8]
    else $error("word changed without a run edge");
  // soft sleep acts one edge after the write, the pin pays two sync edges more
  a_soft_sleep_on: assert property (ctrl_ff[POC_CTRL_SLEEP_BIT] |=> shutdown_out) // [R3]
    else $error("soft sleep not honoured");
  a_wake_two_edges: assert property ( // [R3]
    (!sleep_request_in && !ctrl_ff[POC_CTRL_SLEEP_BIT])[*3] |=> !shutdown_out)
    else $error("converter stayed down with sleep released");
  a_overrun_set_wins: assert property (cap_lost |=> overrun_ff)
    else $error("lost word did not flag overrun");
  a_lane_off_ignored: assert property ((avs_write_in && !avs_byteenable_in[0])
    |=> $stable(ctrl_ff))
    else $error("write with lane 0 off changed control");
  a_bus_one_wait: assert property ($rose(avs_read_in || avs_write_in)
    |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("bus answer not after one wait cycle");
  a_ctrl_read_back: assert property ((avs_read_in && sel_ctrl && !avs_waitrequest_out)
    |-> avs_readdata_out == {29'h0, ctrl_ff})
    else $error("control read back wrong");

  c_sleep_enter: cover property (run_ff ##1 !run_ff);
  c_fifo_full: cover property (!fifo_in_ready);
  c_data_read: cover property (fifo_pop && fifo_out_valid);
  c_overrun_clear: cover property (overrun_ff ##1 ovr_clear ##1 !overrun_ff);
  c_soft_sleep: cover property (ctrl_ff[POC_CTRL_SLEEP_BIT] ##1 shutdown_out);

endmodule : poc_output_ctrl

/* File: poc_pkg.sv */
// constants, types and correction function for the converter output control block
package poc_pkg;

  // ***************************************************************
  // timing and widths
  // ***************************************************************
  localparam int POC_CLK_MHZ = 40;
  localparam int POC_WORD_W = 10;
  localparam int POC_STAGES = 9;
  localparam int POC_CODE_W = 2 * POC_STAGES;
  localparam int POC_LATENCY = 5;
  localparam int POC_SYNC_DEPTH = 2;
  localparam int POC_ALIGN_DEPTH = POC_LATENCY - POC_SYNC_DEPTH;
  localparam int POC_FIFO_DEPTH = 32;

  // ***************************************************************
  // register map (byte addresses) and fields
  // ***************************************************************
  localparam logic [3:0] POC_CTRL_OFS = 4'h0;
  localparam logic [3:0] POC_STATUS_OFS = 4'h4;
  localparam logic [3:0] POC_DATA_OFS = 4'h8;
  localparam int POC_CTRL_SLEEP_BIT = 0;
  localparam int POC_CTRL_CAPTURE_BIT = 1;
  localparam int POC_CTRL_TWOS_BIT = 2;
  localparam int POC_ST_ASLEEP_BIT = 0;
  localparam int POC_ST_SPAN_BIT = 1;
  localparam int POC_ST_EXTREF_BIT = 2;
  localparam int POC_ST_OVERRUN_BIT = 3;
  localparam int POC_ST_EMPTY_BIT = 4;
  localparam int POC_ST_FULL_BIT = 5;
  localparam int POC_ST_LEVEL_LSB = 8;
  localparam int POC_DATA_VALID_BIT = 31;
  localparam logic [2:0] POC_CTRL_RESET = 3'h0;

  // ***************************************************************
  // codes
  // ***************************************************************
  localparam logic [1:0] POC_STAGE_BAD = 2'h3;
  localparam logic [1:0] POC_STAGE_TOP = 2'h2;
  localparam logic [POC_CODE_W-1:0] POC_MID_CODES = 18'h1_5556;
  localparam logic [POC_WORD_W-1:0] POC_MID_WORD = 10'h200;

  typedef enum logic [1:0]
  {
    POC_BUS_IDLE = 2'b01,
    POC_BUS_ACK = 2'b10
  } poc_bus_state_t;

  // 1.5-bit stages overlap by one bit; the redundancy absorbs comparator
  // offsets so adding the shifted decisions leaves no missing codes
  function automatic logic [POC_WORD_W-1:0] poc_correct(input logic [POC_CODE_W-1:0] codes);
    logic [POC_WORD_W:0] sum;
    logic [1:0] d;
    sum = '0;
    for (int k = 0; k < POC_STAGES - 1; k++)
    begin
      d = codes[POC_CODE_W-1-2*k -: 2];
      if (d == POC_STAGE_BAD)
        d = POC_STAGE_TOP;
      sum = sum + ((POC_WORD_W+1)'(d) << (POC_STAGES - 1 - k));
    end
    sum = sum + (POC_WORD_W+1)'(codes[1:0]);
    poc_correct = sum[POC_WORD_W-1:0];
  endfunction : poc_correct

endpackage : poc_pkg

/* File: poc_fifo.sv */
// sample word fifo with valid/ready on both sides
`timescale 1ns/100ps
module poc_fifo
  import poc_pkg::*;
#(
  parameter int WIDTH = POC_WORD_W,
  parameter int DEPTH = POC_FIFO_DEPTH
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH):0] level_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  wire logic full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  wire logic empty = (wr_ptr_ff == rd_ptr_ff);
  wire logic push = in_valid_in && !full;
  wire logic pop = out_ready_in && !empty;

  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_ff[rd_ptr_ff[AW-1:0]];
  assign level_out = wr_ptr_ff - rd_ptr_ff;

  // ***************************************************************
  // storage: no reset on the array keeps it mappable to ram
  // ***************************************************************
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_in;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

endmodule : poc_fifo

/* File: poc_capture_model.sv */
// capture-side partner model that latches the parallel sample words
`timescale 1ns/100ps
module poc_capture_model
  import poc_pkg::*;
(
  input wire logic clk_in,
  input wire logic shutdown_in,
  input wire logic [1:POC_WORD_W] word_in,
  input wire logic [1:POC_WORD_W] oe_in,
  output logic [POC_WORD_W-1:0] word_out,
  output logic ok_out
);
  // ***************************************************************
  // pin level and capture
  // ***************************************************************
  logic [1:POC_WORD_W] pins;
  logic [1:POC_WORD_W] last_ff = '0;
  int wait_ff = POC_LATENCY;
  // data pins have no pull: a floated bit shows the inverse of its last level
  always_comb
    for (int i = 1; i <= POC_WORD_W; i++)
      pins[i] = oe_in[i] ? word_in[i] : ~last_ff[i];
  // latch on the rising edge, word taken as stable between edges
  always @(posedge clk_in)
  begin
    last_ff <= pins;
    word_out <= pins;
    // stale words dropped until the pipeline has refilled
    wait_ff <= shutdown_in ? POC_LATENCY : ((wait_ff > 0) ? wait_ff - 1 : 0);
  end
  assign ok_out = (wait_ff == 0) && !shutdown_in;
endmodule : poc_capture_model

/* File: pipelined_adc_output_control_tb.sv */
// self-checking bench for the converter output control block
`timescale 1ns/100ps
module pipelined_adc_output_control_tb
  import poc_pkg::*;
;
  // ***************************************************************
  // stimulus signals, notes and helpers
  // ***************************************************************
  typedef struct {logic [9:0] w; int due;} poc_note_t;
  poc_note_t notes[$];
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [POC_CODE_W-1:0] code = '0;
  logic oe_n = 1'b0, oe_drv = 1'b1, sleep = 1'b0;
  logic span = 1'b1, span_drv = 1'b1, ref_sel = 1'b1, ref_drv = 1'b1;
  logic [3:0] addr = '0, be = '0;
  logic rd = 1'b0, wr = 1'b0;
  logic [31:0] wdata = '0, rdata_out, rdata;
  logic wreq;
  logic [1:POC_WORD_W] word, oe, held;
  logic span_o, ext_o, shut;
  logic [9:0] cap_word;
  logic cap_ok;
  int bad_count = 0, n_tests = 0, cyc = 0, seed = 14;
  logic [17:0] k_code = 18'h2_9A5C;

  poc_output_ctrl #(.FIFO_DEPTH(4)) DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .stage_code_in(code), .oe_n_in(oe_n), .oe_n_driven_in(oe_drv),
    .sleep_request_in(sleep), .input_span_select_in(span),
    .input_span_select_driven_in(span_drv), .reference_source_select_in(ref_sel),
    .reference_source_select_driven_in(ref_drv), .sample_word_out(word),
    .sample_word_oe_out(oe), .span_2v_out(span_o), .ext_ref_out(ext_o),
    .shutdown_out(shut), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata_out),
    .avs_waitrequest_out(wreq));
  poc_capture_model capture (.clk_in(clk_in), .shutdown_in(shut), .word_in(word),
    .oe_in(oe), .word_out(cap_word), .ok_out(cap_ok));

  initial
    forever #12.5 clk_in = ~clk_in;

  // bounded run: the whole sequence needs well under a thousand cycles
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // own reference: overlapping stage decisions summed, top code folded to two
  function automatic logic [9:0] exp_word(input logic [17:0] c);
    logic [10:0] s;
    logic [1:0] d;
    s = '0;
    for (int k = 0; k < 8; k++)
    begin
      d = c[17-2*k -: 2];
      s = s + (11'((d == 2'h3) ? 2'h2 : d) << (8 - k));
    end
    exp_word = s[9:0] + 10'(c[1:0]);
  endfunction : exp_word

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    addr <= a;
    wdata <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk_in);
    end while (wreq !== 1'b0);
    rdata = rdata_out;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_in);
  endtask : bus

  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string what);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    check(rdata & m, e, what);
  endtask : rdc

  task automatic put(input logic [17:0] c);
    @(posedge clk_in);
    code <= c;
    notes.push_back('{exp_word(c), cyc + 7});
  endtask : put

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : idle

  task automatic wait_shut(input logic v);
    for (int n = 0; n < 10 && shut !== v; n++)
      @(posedge clk_in);
    check({31'h0, shut}, {31'h0, v}, "shutdown");
  endtask : wait_shut

  // the watcher takes the oldest note once its word has been latched
  always @(negedge clk_in)
    if (notes.size() > 0 && notes[0].due <= cyc)
    begin
      n_tests++;
      if (cap_ok !== 1'b1 || cap_word !== notes[0].w || notes[0].due != cyc)
      begin
        bad_count++;
        $display("BAD %0t sample word %h exp %h", $time, cap_word, notes[0].w);
      end
      void'(notes.pop_front());
    end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial
  begin
    idle(8);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    rdc(POC_CTRL_OFS, 32'hFFFF_FFFF, 32'(POC_CTRL_RESET), "ctrl reset");
    bus(1'b1, POC_CTRL_OFS, 32'h0000_0004, 4'h0);
    rdc(POC_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000, "lane off write");
    rdc(4'hC, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    idle(6);
    put(18'h0_0000);
    put(18'h3_FFFF);
    put(POC_MID_CODES);
    repeat (40) put(18'($random(seed)));
    idle(8);
    for (int i = 0; i < 8; i++)
    begin
      span <= i[0];
      ref_sel <= i[1];
      span_drv <= i[2];
      ref_drv <= i[2];
      idle(3);
      check({30'h0, span_o, ext_o}, {30'h0, i[2] ? i[0] : 1'b1, i[2] ? i[1] : 1'b1}, "straps");
      rdc(POC_STATUS_OFS, 32'h0000_0006, {29'h0, i[2] ? i[1] : 1'b1, i[2] ? i[0] : 1'b1, 1'b0}, "strap status");
    end
    for (int i = 0; i < 3; i++)
    begin
      oe_n <= (i > 0);
      oe_drv <= (i != 2);
      idle(3);
      check({22'h0, oe}, (i == 1) ? 32'h0000_0000 : 32'h0000_03FF, "drive enable");
    end
    oe_n <= 1'b0;
    oe_drv <= 1'b1;
    sleep <= 1'b1;
    wait_shut(1'b1);
    held = word;
    // a fresh code while asleep shows whether the pipeline really froze
    code <= k_code;
    idle(4);
    check({22'h0, word}, {22'h0, held}, "word held asleep");
    rdc(POC_STATUS_OFS, 32'h0000_0001, 32'h0000_0001, "asleep status");
    sleep <= 1'b0;
    wait_shut(1'b0);
    bus(1'b1, POC_CTRL_OFS, 32'h0000_0001, 4'hf);
    wait_shut(1'b1);
    bus(1'b1, POC_CTRL_OFS, 32'h0000_0000, 4'hf);
    wait_shut(1'b0);
    repeat (20) put(18'($random(seed)));
    idle(8);
    code <= k_code;
    idle(8);
    // fifo fills from a steady word so every entry has one known value
    bus(1'b1, POC_CTRL_OFS, 32'h0000_0006, 4'hf);
    for (int n = 0; n < 20 && rdata[POC_ST_FULL_BIT] !== 1'b1; n++)
      bus(1'b0, POC_STATUS_OFS, 32'h0000_0000, 4'hf);
    rdc(POC_STATUS_OFS, 32'h0000_0028, 32'h0000_0028, "full and overrun");
    bus(1'b1, POC_CTRL_OFS, 32'h0000_0004, 4'hf);
    repeat (4) rdc(POC_DATA_OFS, 32'h8000_03FF, {1'b1, 21'h0, exp_word(k_code) ^ 10'h200}, "fifo word");
    rdc(POC_DATA_OFS, 32'h8000_0000, 32'h0000_0000, "empty pop");
    rdc(POC_STATUS_OFS, 32'h0000_3F10, 32'h0000_0010, "drained");
    bus(1'b1, POC_STATUS_OFS, 32'h0000_0008, 4'hf);
    rdc(POC_STATUS_OFS, 32'h0000_0008, 32'h0000_0000, "overrun cleared");
    stop_test();
  end
endmodule : pipelined_adc_output_control_tb
